// [hdl/operating_mode_field_pkg.sv]
// constants, types and status layout for the operating-mode sequencer
package operating_mode_field_pkg;

	// ------------------------------------------------------------
	// clock and time constants
	// ------------------------------------------------------------
	localparam int CLK_MHZ                = 50;
	localparam int LONG_OPEN_WINDOW_US    = 200000;
	localparam int RESET_DELAY_TIME_US    = 10000;
	localparam int CONFIG_FILTER_TIME_US  = 10;
	localparam int WD_BASE_PERIOD_US      = 10000;
	localparam int LONG_OPEN_WINDOW_CYC   = LONG_OPEN_WINDOW_US * CLK_MHZ;
	localparam int RESET_DELAY_TIME_CYC   = RESET_DELAY_TIME_US * CLK_MHZ;
	localparam int CONFIG_FILTER_TIME_CYC = CONFIG_FILTER_TIME_US * CLK_MHZ;
	localparam int WD_BASE_PERIOD_CYC     = WD_BASE_PERIOD_US * CLK_MHZ;

	// ------------------------------------------------------------
	// serial frame layout
	// ------------------------------------------------------------
	localparam int         FRAME_BITS      = 16;
	localparam int         FRAME_WRITE_BIT = 15;
	localparam int         FRAME_TGT_LSB   = 12;
	localparam logic [1:0] TGT_MODE        = 2'h0;
	localparam logic [1:0] TGT_WD          = 2'h1;
	localparam logic [1:0] TGT_HW          = 2'h2;
	localparam logic [1:0] TGT_STAT        = 2'h3;
	localparam int         MODE_FIELD_LSB  = 0;
	localparam int         OV_RST_BIT      = 2;
	localparam int         WD_SET_LSB      = 0;
	localparam int         CFG_BIT         = 0;
	localparam int         CLR_POR_BIT     = 1;
	localparam int         CLR_OV_BIT      = 2;
	localparam int         CLR_WAKE_BIT    = 3;

	// ------------------------------------------------------------
	// mode field codes and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_NORMAL  = 2'h0;
	localparam logic [1:0] MODE_SLEEP   = 2'h1;
	localparam logic [1:0] MODE_STOP    = 2'h2;
	localparam logic       CFG_RESET    = 1'b1;
	localparam logic       OV_RST_RESET = 1'b0;
	localparam logic [3:0] WD_SET_RESET = 4'h0;
	localparam logic [1:0] WD_FAILS_MAX = 2'h2;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_NORMAL,
		ST_STOP,
		ST_SLEEP,
		ST_RESTART,
		ST_FAILSAFE
	} op_state_t;

	// readback word: hardware control and wake-level status bits
	typedef struct packed {
		logic [1:0] operating_mode_field;
		logic       pin_latched_level;
		logic       cfg;
		logic       overvoltage_flag;
		logic       por_flag;
		logic       wake_seen;
		logic       dev_mode;
	} status_t;

endpackage : operating_mode_field_pkg

// [hdl/operating_mode_field_and_failure_config.sv]
// operating-mode state machine with pin-latched failure configuration
`timescale 1ns/1ps
module operating_mode_field_and_failure_config #(
	parameter int LONG_OPEN_WINDOW_CYCLES = operating_mode_field_pkg::LONG_OPEN_WINDOW_CYC,
	parameter int RESET_DELAY_CYCLES      = operating_mode_field_pkg::RESET_DELAY_TIME_CYC,
	parameter int WD_BASE_CYCLES          = operating_mode_field_pkg::WD_BASE_PERIOD_CYC
) (
	input  wire logic                    clk_sys,
	input  wire logic                    arst_n,
	input  wire logic                    main_reg_ok,
	input  wire logic                    main_reg_ov,
	input  wire logic                    overtemp,
	input  wire logic                    wake_can,
	input  wire logic                    wake_lin,
	input  wire logic                    wake_pin,
	input  wire logic                    test_pin,
	input  wire logic                    int_pin_in,
	output logic                         int_pd_en,
	input  wire logic                    spi_cs_n,
	input  wire logic                    spi_sck,
	input  wire logic                    spi_mosi,
	output logic                         spi_miso,
	output logic                         reset_output,
	output logic                         main_reg_en,
	output logic                         fail_outputs,
	output logic                         wd_fail_evt,
	output operating_mode_field_pkg::op_state_t      op_state,
	output operating_mode_field_pkg::status_t        status
);
	import operating_mode_field_pkg::*;

	// serial, watchdog, delay and filter state
	logic [31:0] wd_cnt, wd_limit, rd_cnt;
	logic [15:0] rx_shift, tx_shift, flt_cnt;
	logic [4:0]  bit_cnt;
	logic [3:0]  wd_setting;
	logic [1:0]  operating_mode_field, wd_fails;
	logic        sck_q, cs_q, frame_end, frame_ok, wr_frame, wr_mode, wr_wd, wr_hw;
	logic        ov_reset_enable, cfg, por_flag, overvoltage_flag, wake_seen, dev_mode;
	logic        pin_latched_level, wd_long, wd_run, rd_done, cfg_q, flt_stable;
	logic        ov_q, ot_q, ov_evt, ot_release, wake_any, ro_rise;

	// frame decode, input edges and readback shared by the processes below
	assign frame_ok   = (bit_cnt == 5'(FRAME_BITS));
	assign wr_frame   = frame_end && frame_ok && rx_shift[FRAME_WRITE_BIT];
	assign wr_mode    = wr_frame && rx_shift[FRAME_TGT_LSB +: 2] == TGT_MODE;
	assign wr_wd      = wr_frame && rx_shift[FRAME_TGT_LSB +: 2] == TGT_WD;
	assign wr_hw      = wr_frame && rx_shift[FRAME_TGT_LSB +: 2] == TGT_HW;
	assign ov_evt     = main_reg_ov && !ov_q;
	assign ot_release = ot_q && !overtemp;
	assign wake_any   = wake_can || wake_lin || wake_pin;
	assign rd_done    = (rd_cnt >= 32'(RESET_DELAY_CYCLES - 1));
	assign ro_rise    = rd_done && !reset_output && main_reg_ok && !main_reg_ov
	                    && (op_state == ST_INIT || op_state == ST_RESTART);
	assign spi_miso   = tx_shift[15];
	assign status     = {operating_mode_field, pin_latched_level, cfg, overvoltage_flag,
	                     por_flag, wake_seen, dev_mode};

	// ------------------------------------------------------------
	// serial frame receiver, sixteen bits per frame
	// ------------------------------------------------------------
	// edge history of the serial clock and select inputs and the overvoltage and overtemperature inputs
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sck_q <= 1'b0;
			cs_q  <= 1'b1;
			ov_q  <= 1'b0;
			ot_q  <= 1'b0;
		end else begin
			sck_q <= spi_sck;
			cs_q  <= spi_cs_n;
			ov_q  <= main_reg_ov;
			ot_q  <= overtemp;
		end
	end

	// shift in on rising clock, out on falling; reply loaded at select
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rx_shift  <= 16'h0000;
			tx_shift  <= 16'h0000;
			bit_cnt   <= 5'h00;
			frame_end <= 1'b0;
		end else begin
			frame_end <= 1'b0;
			if (cs_q && !spi_cs_n) begin
				bit_cnt  <= 5'h00;
				tx_shift <= {8'h00, status};
			end else if (!spi_cs_n && spi_sck && !sck_q) begin
				rx_shift <= {rx_shift[14:0], spi_mosi};
				if (bit_cnt != 5'h1F)
					bit_cnt <= bit_cnt + 5'h01;
			end else if (!spi_cs_n && !spi_sck && sck_q) begin
				tx_shift <= {tx_shift[14:0], 1'b0};
			end
			if (!cs_q && spi_cs_n)
				frame_end <= 1'b1;  // any frame, legal or not
		end
	end

	// ------------------------------------------------------------
	// software control bits
	// ------------------------------------------------------------
	// the mode field is forced to normal in restart so it mirrors the mode
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			operating_mode_field <= MODE_NORMAL;
			ov_reset_enable      <= OV_RST_RESET;
			cfg                  <= CFG_RESET;
		end else begin
			if (op_state == ST_RESTART)
				operating_mode_field <= MODE_NORMAL;
			else if (wr_mode)
				operating_mode_field <= rx_shift[MODE_FIELD_LSB +: 2];
			if (wr_mode)
				ov_reset_enable <= rx_shift[OV_RST_BIT];
			if (wr_hw)
				cfg <= rx_shift[CFG_BIT];
		end
	end

	// sticky flags: a hardware set in the same cycle beats a clear
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			por_flag         <= 1'b1;
			overvoltage_flag <= 1'b0;
			wake_seen        <= 1'b0;
		end else begin
			if (wr_hw && rx_shift[CLR_POR_BIT])
				por_flag <= 1'b0;
			if (ov_evt)
				overvoltage_flag <= 1'b1;
			else if (wr_hw && rx_shift[CLR_OV_BIT])
				overvoltage_flag <= 1'b0;
			if (wake_any && op_state != ST_INIT)
				wake_seen <= 1'b1;
			else if (wr_hw && rx_shift[CLR_WAKE_BIT])
				wake_seen <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// reset delay and hardware configuration capture
	// ------------------------------------------------------------
	// counts only while the regulator is good and the reset is held low
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_cnt <= 32'h0000_0000;
		end else if (reset_output || !main_reg_ok || main_reg_ov
		             || (op_state != ST_INIT && op_state != ST_RESTART)) begin
			rd_cnt <= 32'h0000_0000;
		end else if (!rd_done) begin
			rd_cnt <= rd_cnt + 32'h0000_0001;
		end
	end

	// pull-down is on whenever reset is low and the regulator is good, and only while por is set
	assign int_pd_en = !reset_output && main_reg_ok && por_flag;

	// continuous filter: level must hold unchanged for the filter time
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q      <= 1'b0;
			flt_cnt    <= 16'h0000;
			flt_stable <= 1'b0;
		end else begin
			cfg_q <= int_pin_in;
			if (!int_pd_en || int_pin_in != cfg_q) begin
				flt_cnt    <= 16'h0000;
				flt_stable <= 1'b0;
			end else if (flt_cnt >= 16'(CONFIG_FILTER_TIME_CYC - 1)) begin
				flt_stable <= 1'b1;
			end else begin
				flt_cnt <= flt_cnt + 16'h0001;
			end
		end
	end

	// latched at each reset release while por is set; once por is cleared only power loss (async reset) frees it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pin_latched_level <= 1'b0;
		end else if (ro_rise && por_flag) begin
			pin_latched_level <= flt_stable && cfg_q;
		end
	end

	// development mode is chosen from the test pin while still in init
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dev_mode <= 1'b0;
		end else if (op_state == ST_INIT) begin
			dev_mode <= !test_pin;
		end
	end

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	assign wd_run   = reset_output && !dev_mode
	                  && (op_state == ST_INIT || op_state == ST_NORMAL
	                      || op_state == ST_STOP);
	assign wd_limit = wd_long ? 32'(LONG_OPEN_WINDOW_CYCLES - 1)  // setting 15 must not wrap
	                          : 32'(WD_BASE_CYCLES) * {27'h0, {1'b0, wd_setting} + 5'h01} - 32'h1;

	// a trigger restarts the window; restart re-arms the long window
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wd_long     <= 1'b1;
			wd_cnt      <= 32'h0000_0000;
			wd_setting  <= WD_SET_RESET;
			wd_fail_evt <= 1'b0;
		end else begin
			wd_fail_evt <= 1'b0;
			if (op_state == ST_RESTART || !wd_run) begin
				wd_cnt <= 32'h0000_0000;
				if (op_state == ST_RESTART)
					wd_long <= 1'b1;
			end else if (wr_wd) begin
				wd_setting <= rx_shift[WD_SET_LSB +: 4];
				wd_long    <= 1'b0;
				wd_cnt     <= 32'h0000_0000;
			end else if (wd_cnt >= wd_limit) begin
				wd_fail_evt <= 1'b1;
				wd_cnt      <= 32'h0000_0000;
			end else begin
				wd_cnt <= wd_cnt + 32'h0000_0001;
			end
		end
	end

	// failure count saturates at two; fail outputs latch until power loss
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wd_fails     <= 2'h0;
			fail_outputs <= 1'b0;
		end else begin
			if (wd_fail_evt && wd_fails != WD_FAILS_MAX)
				wd_fails <= wd_fails + 2'h1;
			if (wd_fail_evt && (cfg || wd_fails != 2'h0))
				fail_outputs <= 1'b1;
			if (ov_evt && ov_reset_enable)
				fail_outputs <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// operating-mode state machine
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			op_state     <= ST_INIT;
			reset_output <= 1'b0;
			main_reg_en  <= 1'b1;
		end else begin
			if (ro_rise)
				reset_output <= 1'b1;
			if (wd_fail_evt) begin
				reset_output <= 1'b0;
				if (pin_latched_level || (!cfg && wd_fails == 2'h0))
					op_state <= ST_RESTART;
				else begin
					op_state    <= ST_FAILSAFE;
					main_reg_en <= 1'b0;
				end
			end else if (ov_evt && ov_reset_enable) begin
				reset_output <= 1'b0;
				if (pin_latched_level)
					op_state <= ST_RESTART;
				else begin
					op_state    <= ST_FAILSAFE;
					main_reg_en <= 1'b0;
				end
			end else begin
				unique case (op_state)
					ST_INIT: begin
						if (frame_end && reset_output)
							op_state <= ST_NORMAL;
					end
					ST_NORMAL, ST_STOP: begin
						if (!main_reg_ok) begin
							op_state     <= ST_RESTART;
							reset_output <= 1'b0;
						end else if (wr_mode) begin
							unique case (rx_shift[MODE_FIELD_LSB +: 2])
								MODE_STOP:  op_state <= ST_STOP;
								MODE_SLEEP: begin
									op_state     <= ST_SLEEP;
									main_reg_en  <= 1'b0;
									reset_output <= 1'b0;
								end
								default:    op_state <= ST_NORMAL;
							endcase
						end
					end
					ST_SLEEP: begin
						if (wake_any) begin
							op_state    <= ST_RESTART;
							main_reg_en <= 1'b1;
						end
					end
					ST_RESTART: begin
						if (ro_rise)
							op_state <= ST_NORMAL;
					end
					ST_FAILSAFE: begin
						if (wake_any || ot_release) begin
							op_state    <= ST_RESTART;
							main_reg_en <= 1'b1;
						end
					end
				endcase
			end
		end
	end

endmodule : operating_mode_field_and_failure_config

// [test/operating_mode_field_properties.sv]
// concurrent checks on the operating-mode sequencer ports
`timescale 1ns/1ps
module operating_mode_field_properties #(
	parameter int RESET_DELAY_CYCLES = 600
) (
	input wire logic                clk_sys,
	input wire logic                arst_n,
	input wire logic                main_reg_ok,
	input wire logic                main_reg_ov,
	input wire logic                spi_cs_n,
	input wire logic                int_pd_en,
	input wire logic                reset_output,
	input wire logic                main_reg_en,
	input wire logic                fail_outputs,
	input wire logic                wd_fail_evt,
	input operating_mode_field_pkg::op_state_t  op_state,
	input operating_mode_field_pkg::status_t    status
);
	import operating_mode_field_pkg::*;

	// ------------------------------------------------------------
	// helper: cycles spent in restart, so a stuck restart is seen
	// ------------------------------------------------------------
	logic [15:0] rst_cnt;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			rst_cnt <= 16'h0000;
		else if (op_state != ST_RESTART)
			rst_cnt <= 16'h0000;
		else
			rst_cnt <= rst_cnt + 16'h0001;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_leave_restart;
		$past(op_state) == ST_RESTART ##0 op_state != ST_RESTART;
	endsequence
	sequence s_held_restart;
		op_state == ST_RESTART [*2];
	endsequence

	chk_pd_enable: assert property (
		int_pd_en == (!reset_output && main_reg_ok && status.por_flag))
		else $error("pull-down enable wrong");
	chk_wd_restart: assert property (
		wd_fail_evt && status.pin_latched_level |=> op_state == ST_RESTART && !reset_output)
		else $error("failure with high strap did not restart");
	chk_wd_failsafe: assert property (
		wd_fail_evt && !status.pin_latched_level && status.cfg
		|=> op_state == ST_FAILSAFE && fail_outputs)
		else $error("failure with low strap did not reach fail-safe");
	chk_fs_reg_off: assert property (
		op_state == ST_FAILSAFE && $past(op_state) == ST_FAILSAFE |-> !main_reg_en && !reset_output)
		else $error("regulator on in fail-safe");
	chk_dev_no_wd: assert property (
		status.dev_mode |-> !wd_fail_evt)
		else $error("watchdog failure in development mode");
	chk_restart_len: assert property (
		op_state == ST_RESTART |-> rst_cnt < RESET_DELAY_CYCLES + 8)
		else $error("restart held too long");
	chk_restart_exit: assert property (
		s_leave_restart |-> op_state == ST_NORMAL && reset_output)
		else $error("restart left to wrong mode");
	chk_mode_clear: assert property (
		s_held_restart |-> status.operating_mode_field == MODE_NORMAL)
		else $error("mode field not cleared in restart");
	chk_init_wake: assert property (
		op_state == ST_INIT |-> !status.wake_seen)
		else $error("wake recorded in init");
	chk_init_exit: assert property (
		$rose(spi_cs_n) && op_state == ST_INIT && reset_output |-> ##[1:6] op_state == ST_NORMAL)
		else $error("frame did not leave init");
	chk_ov_flag: assert property (
		$rose(main_reg_ov) |-> ##[1:4] status.overvoltage_flag)
		else $error("overvoltage flag not set");
endmodule : operating_mode_field_properties

bind operating_mode_field_and_failure_config operating_mode_field_properties #(
	.RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
) u_props (
	.clk_sys, .arst_n, .main_reg_ok, .main_reg_ov, .spi_cs_n, .int_pd_en,
	.reset_output, .main_reg_en, .fail_outputs, .wd_fail_evt, .op_state, .status
);

// [test/host_mcu_model.sv]
// host microcontroller model sending serial frames to the sequencer
`timescale 1ns/1ps
module host_mcu_model (
	input  wire logic        clk_sys,
	input  wire logic        spi_miso,
	output logic             spi_cs_n,
	output logic             spi_sck,
	output logic             spi_mosi,
	output logic             rx_valid,
	output logic [15:0]      rx_word
);
	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		spi_mosi = 1'b0;
		rx_valid = 1'b0;
		rx_word = 16'h0000;
	end

	// ------------------------------------------------------------
	// one frame, msb first, clock low for four clocks and high for two per bit
	// ------------------------------------------------------------
	// a count other than sixteen makes a frame the device must refuse
	task automatic xfer(input logic [15:0] w, input int n, input bit chk);
		@(posedge clk_sys);
		spi_cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			repeat (2) @(posedge clk_sys);
			spi_mosi <= w[15 - i];
			repeat (2) @(posedge clk_sys);
			spi_sck <= 1'b1;
			rx_word <= {rx_word[14:0], spi_miso};
			repeat (2) @(posedge clk_sys);
			spi_sck <= 1'b0;
		end
		repeat (2) @(posedge clk_sys);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi; // released line never repeats the last bit
		rx_valid <= chk && n == 16;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : xfer
endmodule : host_mcu_model

// [test/testbench.sv]
// self-checking bench for the operating-mode sequencer
`timescale 1ns/1ps
module testbench;
	import operating_mode_field_pkg::*;
	localparam int LW = 1200;
	localparam int RD = 600;
	localparam int WB = 400;
	logic clk_sys, arst_n, main_reg_ok, main_reg_ov, overtemp, wake_can, wake_lin, wake_pin;
	logic test_pin, int_pin_in, int_pd_en, spi_cs_n, spi_sck, spi_mosi, spi_miso;
	logic reset_output, main_reg_en, fail_outputs, wd_fail_evt, rx_valid, pull_up, noisy, wk_noise;
	logic [15:0] rx_word;
	logic [31:0] seed;
	op_state_t   op_state;
	status_t     status;
	logic [15:0] exp_q[$];
	int          error_cnt;
	int          check_count;

	operating_mode_field_and_failure_config #(
		.LONG_OPEN_WINDOW_CYCLES(LW),
		.RESET_DELAY_CYCLES     (RD),
		.WD_BASE_CYCLES         (WB)
	) dut (
		.clk_sys, .arst_n, .main_reg_ok, .main_reg_ov, .overtemp, .wake_can, .wake_lin,
		.wake_pin, .test_pin, .int_pin_in, .int_pd_en, .spi_cs_n, .spi_sck, .spi_mosi,
		.spi_miso, .reset_output, .main_reg_en, .fail_outputs, .wd_fail_evt, .op_state, .status
	);
	host_mcu_model host (.clk_sys, .spi_miso, .spi_cs_n, .spi_sck, .spi_mosi, .rx_valid, .rx_word);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic wait_st(input op_state_t s, input int lim);
		for (int i = 0; i < lim && op_state !== s; i++) @(posedge clk_sys);
		check({13'h0000, op_state}, {13'h0000, s});
	endtask : wait_st

	// test pin must stay put for the whole init phase
	task automatic power_up(input logic pu, input logic nz, input logic tp);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		pull_up <= pu;
		noisy <= nz;
		test_pin <= tp;
		wk_noise <= 1'b1;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		for (int i = 0; i < 2 * RD && reset_output !== 1'b1; i++) @(posedge clk_sys);
		wk_noise <= 1'b0;
		noisy <= 1'b0;
		check({13'h0000, op_state}, {13'h0000, ST_INIT});
	endtask : power_up

	task automatic wr(input logic [1:0] t, input logic [11:0] d);
		host.xfer({2'h2, t, d}, 16, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] e);
		exp_q.push_back({8'h00, e});
		host.xfer({2'h0, TGT_STAT, 12'h000}, 16, 1'b1);
	endtask : rd

	// strap line: pull-up wins over the weak pull-down, floating line wanders
	always @(posedge clk_sys) begin
		seed <= xs(seed);
		int_pin_in <= noisy ? seed[0] : (pull_up | (!int_pd_en & seed[1]));
		wake_pin <= wk_noise & seed[2];
	end

	// replies are matched against the oldest noted expectation
	always @(posedge clk_sys) begin
		if (rx_valid) begin
			if (exp_q.size() == 0)
				check(rx_word, ~rx_word);
			else
				check(rx_word, exp_q.pop_front());
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// three scenarios need far fewer cycles than this
	initial begin
		repeat (40 * LW) @(posedge clk_sys);
		error_cnt++;
		summarize();
	end

	initial begin
		{arst_n, main_reg_ov, overtemp, wake_can, wake_lin, wake_pin, int_pin_in} = 7'h00;
		{main_reg_ok, test_pin, pull_up, noisy, wk_noise} = 5'h1C;
		seed = 32'h00002861;
		error_cnt = 0;
		check_count = 0;
		// pull-up strap, no trigger: restart, then normal
		power_up(1'b1, 1'b0, 1'b1);
		check({15'h0000, status.pin_latched_level}, 16'h0001);
		wait_st(ST_RESTART, 2 * LW);
		check({15'h0000, fail_outputs}, 16'h0001);
		wait_st(ST_NORMAL, 2 * RD);
		wr(TGT_WD, 12'h00F);
		rd({MODE_NORMAL, 1'b1, CFG_RESET, 4'h4});
		$display("test init timeout done");
		// development mode, noisy strap, overvoltage handling, sleep round trip
		power_up(1'b0, 1'b1, 1'b0);
		check({15'h0000, status.pin_latched_level}, 16'h0000);
		host.xfer(16'hFFFF, 5, 1'b0);
		wait_st(ST_NORMAL, 8);
		check({15'h0000, status.dev_mode}, 16'h0001);
		wr(TGT_HW, 12'h002);
		wr(TGT_MODE, {10'h000, MODE_STOP});
		rd({MODE_STOP, 1'b0, 1'b0, 4'h1});
		main_reg_ov <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check({status.overvoltage_flag, fail_outputs, 11'h000, op_state}, {2'h2, 11'h000, ST_STOP});
		main_reg_ov <= 1'b0;
		wr(TGT_MODE, {9'h000, 1'b1, MODE_NORMAL});
		main_reg_ov <= 1'b1;
		wait_st(ST_FAILSAFE, 8);
		check({14'h0000, fail_outputs, main_reg_en}, 16'h0002);
		{main_reg_ov, pull_up, wake_lin} <= 3'h3;
		@(posedge clk_sys);
		wake_lin <= 1'b0;
		wait_st(ST_RESTART, 8);
		wait_st(ST_NORMAL, 2 * RD);
		check({13'h0000, status.pin_latched_level, status.operating_mode_field}, {14'h0000, MODE_NORMAL});
		// sleep drops regulator and reset; a bus wake comes back through restart
		wr(TGT_MODE, {10'h000, MODE_SLEEP});
		wait_st(ST_SLEEP, 8);
		check({14'h0000, main_reg_en, reset_output}, 16'h0000);
		wake_can <= 1'b1;
		@(posedge clk_sys);
		wake_can <= 1'b0;
		wait_st(ST_RESTART, 8);
		wait_st(ST_NORMAL, 2 * RD);
		check({14'h0000, status.operating_mode_field}, {14'h0000, MODE_NORMAL});
		$display("test development mode done");
		// pulled-low strap, two-failure counting; short period proves the trigger took
		power_up(1'b0, 1'b0, 1'b1);
		wr(TGT_HW, 12'h000);
		wr(TGT_WD, 12'h000);
		wait_st(ST_RESTART, 2 * WB);
		check({15'h0000, fail_outputs}, 16'h0000);
		wait_st(ST_NORMAL, 2 * RD);
		wait_st(ST_FAILSAFE, 3 * LW);
		check({15'h0000, fail_outputs}, 16'h0001);
		overtemp <= 1'b1;
		repeat (3) @(posedge clk_sys);
		overtemp <= 1'b0;
		wait_st(ST_RESTART, 8);
		wait_st(ST_NORMAL, 2 * RD);
		wr(TGT_HW, 12'h001);
		wait_st(ST_FAILSAFE, 3 * LW);
		$display("test failure counting done");
		summarize();
	end
endmodule : testbench
